//--- logic/axis_group_command_checker.sv
// Axis-group command checker: validates homing, position set and interpolation commands
// Functional notes
// - Homing refused when drive lacks homing mode
// - Homing failure of any axis posts error
// - Homing refused while group is not idle
// - Position set refused when axis has error
// - Absolute linear move needs determined origins
// - Linear speed must not exceed axis limits
// - Corner distance must stay below move distance
// - Inserted corner arc radius within pulse limit
// - Linear refused with infinite repeat enabled
// - Circular move needs determined origins
// - Circular method must be zero to two
// - Circular direction must be zero or one
// - Radius method radius checked at eighty percent
// - Midpoint or center method auxiliary point must differ from both ends
// - Midpoint or radius method needs distinct ends
`timescale 1ns/1ps
`include "axis_group_consts.svh"
module axis_group_command_checker
  import axis_group_pkg::*;
#(
  parameter int N_AXES = 4,
  parameter int SPEED_W = 32,
  parameter int DIST_W = 32,
  parameter int ARC_W = 40,
  parameter int COORD_W = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic group_idle_state,
  input wire logic [N_AXES-1:0] group_mask,
  input wire logic [N_AXES-1:0] axis_home_unsupported,
  input wire logic [N_AXES-1:0] axis_home_done,
  input wire logic [N_AXES-1:0] axis_home_fail,
  input wire logic [N_AXES-1:0] axis_error,
  input wire logic [N_AXES-1:0] axis_origin_ok,
  input wire logic [N_AXES-1:0] axis_inf_repeat,
  input wire logic [N_AXES-1:0][SPEED_W-1:0] axis_speed_limit,
  input wire logic [SPEED_W-1:0] cmd_speed,
  input wire logic abs_coord,
  input wire logic corner_mode,
  input wire logic [DIST_W-1:0] move_dist,
  input wire logic [DIST_W-1:0] corner_dist,
  input wire logic [ARC_W-1:0] arc_radius,
  input wire logic [7:0] circ_method,
  input wire logic [7:0] circ_dir,
  input wire logic [COORD_W-1:0] circ_radius,
  input wire logic signed [COORD_W-1:0] start_x,
  input wire logic signed [COORD_W-1:0] start_y,
  input wire logic signed [COORD_W-1:0] aux_x,
  input wire logic signed [COORD_W-1:0] aux_y,
  input wire logic signed [COORD_W-1:0] end_x,
  input wire logic signed [COORD_W-1:0] end_y,
  output logic cmd_done,
  output logic cmd_accept,
  output logic cmd_reject,
  output logic motion_start,
  output logic homing_busy,
  output logic [15:0] err_code
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  checker_regs_type state_reg; // Registered state
  checker_regs_type state_next; // Next value of the state
  cmd_op_type op; // Decoded command class
  logic any_home_unsupported; // Scan results over configured axes
  logic all_home_done;
  logic any_home_fail;
  logic any_error;
  logic any_no_origin;
  logic any_inf_repeat;
  logic any_over_speed;
  logic start_eq_end; // Geometry results
  logic aux_on_end;
  logic radius_short;
  logic corner_dist_bad; // Corner transition checks
  logic corner_radius_bad;
  logic [15:0] home_code; // Verdict per command class
  logic [15:0] setpos_code;
  logic [15:0] lin_code;
  logic [15:0] circ_code;
  logic [15:0] verdict; // Verdict of the presented command
  logic take; // Command taken this cycle

  assign op = cmd_op_type'(cmd_op);

  // ****************************************************************
  // Status scan and geometry
  // ****************************************************************
  axis_group_scan #(
    .N_AXES(N_AXES),
    .SPEED_W(SPEED_W)
  ) u_scan (
    .group_mask(group_mask),
    .axis_home_unsupported(axis_home_unsupported),
    .axis_home_done(axis_home_done),
    .axis_home_fail(axis_home_fail),
    .axis_error(axis_error),
    .axis_origin_ok(axis_origin_ok),
    .axis_inf_repeat(axis_inf_repeat),
    .axis_speed_limit(axis_speed_limit),
    .cmd_speed(cmd_speed),
    .any_home_unsupported(any_home_unsupported),
    .all_home_done(all_home_done),
    .any_home_fail(any_home_fail),
    .any_error(any_error),
    .any_no_origin(any_no_origin),
    .any_inf_repeat(any_inf_repeat),
    .any_over_speed(any_over_speed)
  );

  circle_geometry_check #(
    .COORD_W(COORD_W)
  ) u_geom (
    .start_x(start_x),
    .start_y(start_y),
    .aux_x(aux_x),
    .aux_y(aux_y),
    .end_x(end_x),
    .end_y(end_y),
    .radius(circ_radius),
    .start_eq_end(start_eq_end),
    .aux_on_end(aux_on_end),
    .radius_short(radius_short)
  );

  // ****************************************************************
  // Verdicts, first failing check wins
  // ****************************************************************
  // Busy group is tested first: other results are meaningless mid-move
  assign home_code = !group_idle_state ? `ERR_HOME_BUSY :
                     any_home_unsupported ? `ERR_HOME_UNSUPPORTED :
                     `ERR_NONE;

  assign setpos_code = any_error ? `ERR_SETPOS_AXIS_ERROR : `ERR_NONE;

  // Corner figures only matter when corner transition is selected
  assign corner_dist_bad = corner_mode && (corner_dist >= move_dist);
  assign corner_radius_bad = corner_mode &&
                             (arc_radius > {{(ARC_W-32){1'b0}}, `ARC_RADIUS_MAX});

  assign lin_code = (abs_coord && any_no_origin) ? `ERR_LIN_NO_ORIGIN :
                    any_inf_repeat ? `ERR_LIN_INF_REPEAT :
                    any_over_speed ? `ERR_LIN_OVER_SPEED :
                    corner_dist_bad ? `ERR_LIN_CORNER_DIST :
                    corner_radius_bad ? `ERR_LIN_CORNER_RADIUS :
                    `ERR_NONE;

  // Range checks precede geometry, whose meaning depends on the method
  assign circ_code = any_no_origin ? `ERR_CIRC_NO_ORIGIN :
                     (circ_method > `CIRC_METHOD_RADIUS) ? `ERR_CIRC_METHOD :
                     (circ_dir > `CIRC_DIR_MAX) ? `ERR_CIRC_DIRECTION :
                     ((circ_method != `CIRC_METHOD_CENTER) && start_eq_end) ?
                       `ERR_CIRC_SAME_ENDS :
                     ((circ_method != `CIRC_METHOD_RADIUS) && aux_on_end) ?
                       `ERR_CIRC_AUX_POINT :
                     ((circ_method == `CIRC_METHOD_RADIUS) && radius_short) ?
                       `ERR_CIRC_RADIUS :
                     `ERR_NONE;

  // Select by command class
  always_comb begin
    unique case (op)
      OP_HOME: verdict = home_code;
      OP_SETPOS: verdict = setpos_code;
      OP_LINEAR: verdict = lin_code;
      OP_CIRCLE: verdict = circ_code;
    endcase
  end

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  // Only idle takes commands; homing holds the port until it settles
  assign cmd_ready = (state_reg.state == ST_IDLE);
  assign take = cmd_valid && cmd_ready;

  // Next state of the checker
  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    state_next.accept = 1'b0;
    state_next.reject = 1'b0;
    state_next.motion = 1'b0;
    unique case (state_reg.state)
      ST_IDLE: begin
        if (take) begin
          if (verdict != `ERR_NONE) begin
            // Refused: no motion, code stays until the next accept or refusal
            state_next.err_code = verdict;
            state_next.done = 1'b1;
            state_next.reject = 1'b1;
          end else begin
            // Accepted: old code cleared
            state_next.err_code = `ERR_NONE;
            state_next.accept = 1'b1;
            if (op == OP_HOME) begin
              state_next.state = ST_HOMING;
              state_next.motion = 1'b1;
            end else begin
              // Position set moves nothing
              state_next.done = 1'b1;
              state_next.motion = (op != OP_SETPOS);
            end
          end
        end
      end
      ST_HOMING: begin
        // A failure outranks a simultaneous completion
        if (any_home_fail) begin
          state_next.err_code = `ERR_HOME_INCOMPLETE;
          state_next.done = 1'b1;
          state_next.reject = 1'b1;
          state_next.state = ST_IDLE;
        end else if (all_home_done) begin
          state_next.done = 1'b1;
          state_next.state = ST_IDLE;
        end
      end
    endcase
  end

  // State register, synchronous reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= '{state: ST_IDLE, err_code: `ERR_NONE, done: 1'b0,
                     accept: 1'b0, reject: 1'b0, motion: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the register
  assign cmd_done = state_reg.done;
  assign cmd_accept = state_reg.accept;
  assign cmd_reject = state_reg.reject;
  assign motion_start = state_reg.motion;
  assign homing_busy = (state_reg.state == ST_HOMING);
  assign err_code = state_reg.err_code;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_home_busy;
    @(posedge ref_clk) disable iff (rst)
    (take && op == OP_HOME && !group_idle_state) |=>
      cmd_reject && err_code == 16'h2072 && !motion_start;
  endproperty
  a_home_busy: assert property (p_home_busy) else $error("busy homing not refused");

  property p_home_unsup;
    @(posedge ref_clk) disable iff (rst)
    (take && op == OP_HOME && group_idle_state && any_home_unsupported) |=>
      cmd_reject && err_code == 16'h2070;
  endproperty
  a_home_unsup: assert property (p_home_unsup) else $error("homing mode error missing");

  property p_home_fail;
    @(posedge ref_clk) disable iff (rst)
    (homing_busy && any_home_fail) |=> cmd_reject && cmd_done && err_code == 16'h2071 && cmd_ready;
  endproperty
  a_home_fail: assert property (p_home_fail) else $error("homing failure not posted");

  property p_setpos;
    @(posedge ref_clk) disable iff (rst)
    (take && op == OP_SETPOS && any_error) |=> err_code == 16'h2080 && cmd_reject;
  endproperty
  a_setpos: assert property (p_setpos) else $error("position set error missing");

  property p_lin_origin;
    @(posedge ref_clk) disable iff (rst)
    (take && op == OP_LINEAR && abs_coord && any_no_origin) |=> err_code == 16'h2090;
  endproperty
  a_lin_origin: assert property (p_lin_origin) else $error("origin check missed");

  property p_lin_repeat;
    @(posedge ref_clk) disable iff (rst)
    (take && op == OP_LINEAR && !(abs_coord && any_no_origin) && any_inf_repeat) |=>
      err_code == 16'h2094;
  endproperty
  a_lin_repeat: assert property (p_lin_repeat) else $error("repeat check missed");

  property p_circ_method;
    @(posedge ref_clk) disable iff (rst)
    (take && op == OP_CIRCLE && !any_no_origin && circ_method > 8'h02) |=>
      err_code == 16'h20a1;
  endproperty
  a_circ_method: assert property (p_circ_method) else $error("method range missed");

  property p_circ_origin;
    @(posedge ref_clk) disable iff (rst)
    (take && op == OP_CIRCLE && any_no_origin) |=> err_code == 16'h20a0 && !motion_start;
  endproperty
  a_circ_origin: assert property (p_circ_origin) else $error("circle origin missed");

  property p_no_motion;
    @(posedge ref_clk) disable iff (rst)
    cmd_reject |-> !motion_start && !cmd_accept && err_code != 16'h0000;
  endproperty
  a_no_motion: assert property (p_no_motion) else $error("rejected command moved");

  property p_code_hold;
    @(posedge ref_clk) disable iff (rst)
    (!cmd_reject && !cmd_accept) |-> err_code == $past(err_code);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("error code changed");

  c_reject: cover property (@(posedge ref_clk) disable iff (rst) cmd_reject);
  c_linear_ok: cover property (@(posedge ref_clk) disable iff (rst)
    take && op == OP_LINEAR ##1 cmd_accept && motion_start);
  c_homing_done: cover property (@(posedge ref_clk) disable iff (rst)
    homing_busy ##1 cmd_done && !cmd_reject);
  c_circ_radius: cover property (@(posedge ref_clk) disable iff (rst)
    cmd_reject && err_code == 16'h20a3);

endmodule

//--- logic/axis_group_consts.svh
// Constant macros for the axis-group command checker: codes, encodings and thresholds
`ifndef AXIS_GROUP_CONSTS_SVH
`define AXIS_GROUP_CONSTS_SVH

// ****************************************************************
// Posted error codes
// ****************************************************************
`define ERR_NONE 16'h0000
`define ERR_HOME_UNSUPPORTED 16'h2070
`define ERR_HOME_INCOMPLETE 16'h2071
`define ERR_HOME_BUSY 16'h2072
`define ERR_SETPOS_AXIS_ERROR 16'h2080
`define ERR_LIN_NO_ORIGIN 16'h2090
`define ERR_LIN_OVER_SPEED 16'h2091
`define ERR_LIN_CORNER_DIST 16'h2092
`define ERR_LIN_CORNER_RADIUS 16'h2093
`define ERR_LIN_INF_REPEAT 16'h2094
`define ERR_CIRC_NO_ORIGIN 16'h20a0
`define ERR_CIRC_METHOD 16'h20a1
`define ERR_CIRC_DIRECTION 16'h20a2
`define ERR_CIRC_RADIUS 16'h20a3
`define ERR_CIRC_AUX_POINT 16'h20a4
`define ERR_CIRC_SAME_ENDS 16'h20a5

// ****************************************************************
// Operand encodings and limits
// ****************************************************************
`define CIRC_METHOD_MIDPOINT 8'h00
`define CIRC_METHOD_CENTER 8'h01
`define CIRC_METHOD_RADIUS 8'h02
`define CIRC_DIR_MAX 8'h01
`define ARC_RADIUS_MAX 32'h7fff_ffff
// Radius must reach this percentage of half the chord
`define RADIUS_PCT 32'h0000_0050
// 100 squared times 4, clears the division out of the comparison
`define RADIUS_SCALE 32'h0000_9c40

`endif

//--- logic/axis_group_pkg.sv
// Types shared by the axis-group command checker
package axis_group_pkg;

  // Command classes presented by the host
  typedef enum logic [1:0] {OP_HOME, OP_SETPOS, OP_LINEAR, OP_CIRCLE} cmd_op_type;

  // Checker sequencing
  typedef enum logic {ST_IDLE, ST_HOMING} checker_state_type;

  // All state of the checker
  typedef struct packed {
    checker_state_type state;
    logic [15:0] err_code;
    logic done;
    logic accept;
    logic reject;
    logic motion;
  } checker_regs_type;

endpackage

//--- logic/axis_group_scan.sv
// Per-axis scan of the group's status flags, reduced over the configured axes
`timescale 1ns/1ps
module axis_group_scan #(
  parameter int N_AXES = 4,
  parameter int SPEED_W = 32
) (
  input wire logic [N_AXES-1:0] group_mask,
  input wire logic [N_AXES-1:0] axis_home_unsupported,
  input wire logic [N_AXES-1:0] axis_home_done,
  input wire logic [N_AXES-1:0] axis_home_fail,
  input wire logic [N_AXES-1:0] axis_error,
  input wire logic [N_AXES-1:0] axis_origin_ok,
  input wire logic [N_AXES-1:0] axis_inf_repeat,
  input wire logic [N_AXES-1:0][SPEED_W-1:0] axis_speed_limit,
  input wire logic [SPEED_W-1:0] cmd_speed,
  output logic any_home_unsupported,
  output logic all_home_done,
  output logic any_home_fail,
  output logic any_error,
  output logic any_no_origin,
  output logic any_inf_repeat,
  output logic any_over_speed
);

  // Speed excess per configured axis
  logic [N_AXES-1:0] over_vec;

  // ****************************************************************
  // One comparator per axis
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < N_AXES; i++) begin : g_axis
      assign over_vec[i] = group_mask[i] && (cmd_speed > axis_speed_limit[i]);
    end
  endgenerate

  // Axes outside the group never contribute
  assign any_home_unsupported = |(group_mask & axis_home_unsupported);
  assign all_home_done = &(axis_home_done | ~group_mask);
  assign any_home_fail = |(group_mask & axis_home_fail);
  assign any_error = |(group_mask & axis_error);
  assign any_no_origin = |(group_mask & ~axis_origin_ok);
  assign any_inf_repeat = |(group_mask & axis_inf_repeat);
  assign any_over_speed = |over_vec;

endmodule

//--- logic/circle_geometry_check.sv
// Point coincidence and radius plausibility for circular interpolation
`timescale 1ns/1ps
`include "axis_group_consts.svh"
module circle_geometry_check #(
  parameter int COORD_W = 32
) (
  input wire logic signed [COORD_W-1:0] start_x,
  input wire logic signed [COORD_W-1:0] start_y,
  input wire logic signed [COORD_W-1:0] aux_x,
  input wire logic signed [COORD_W-1:0] aux_y,
  input wire logic signed [COORD_W-1:0] end_x,
  input wire logic signed [COORD_W-1:0] end_y,
  input wire logic [COORD_W-1:0] radius,
  output logic start_eq_end,
  output logic aux_on_end,
  output logic radius_short
);

  // Product width covers 40000 times a squared 33-bit span
  localparam int PROD_W = 2 * COORD_W + 20;

  logic signed [COORD_W:0] dx; // Chord span, one bit wider so it never wraps
  logic signed [COORD_W:0] dy;
  logic [2*COORD_W+1:0] dx_sq;
  logic [2*COORD_W+1:0] dy_sq;
  logic [PROD_W-1:0] lhs; // Scaled radius squared
  logic [PROD_W-1:0] rhs; // Scaled chord squared

  // Equality checks need no arithmetic
  assign start_eq_end = (start_x == end_x) && (start_y == end_y);
  assign aux_on_end = ((aux_x == start_x) && (aux_y == start_y)) ||
                      ((aux_x == end_x) && (aux_y == end_y));

  // Squares compared instead of roots, so no divider is needed
  assign dx = {end_x[COORD_W-1], end_x} - {start_x[COORD_W-1], start_x};
  assign dy = {end_y[COORD_W-1], end_y} - {start_y[COORD_W-1], start_y};
  // Widen before squaring: the operand of $unsigned is self-sized and would wrap
  assign dx_sq = $unsigned((2*COORD_W+2)'(dx) * (2*COORD_W+2)'(dx));
  assign dy_sq = $unsigned((2*COORD_W+2)'(dy) * (2*COORD_W+2)'(dy));
  assign lhs = PROD_W'(radius) * PROD_W'(radius) * PROD_W'(`RADIUS_SCALE);
  assign rhs = (PROD_W'(dx_sq) + PROD_W'(dy_sq)) * PROD_W'(`RADIUS_PCT * `RADIUS_PCT);
  assign radius_short = lhs < rhs;

endmodule

//--- test/axis_group_command_checker_tb.sv
// Self-checking testbench for the axis-group command checker
`timescale 1ns/1ps
`include "axis_group_consts.svh"
module axis_group_command_checker_tb;
  // ****************
  // Stimulus and observed signals
  // ****************
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic group_idle_state = 1'b1;
  // Axes 0 and 1 form the group; axis 3 is a decoy outside it
  logic [3:0] group_mask = 4'h3;
  logic [3:0] axis_home_unsupported = 4'h0;
  logic [3:0] axis_error = 4'h0;
  logic [3:0] axis_origin_ok = 4'hf;
  logic [3:0] axis_inf_repeat = 4'h0;
  logic [3:0] fail_axes = 4'h0;
  logic [3:0][31:0] axis_speed_limit = {32'ha, 32'h3e8, 32'h3e8, 32'h3e8};
  logic [31:0] cmd_speed = 32'h1f4;
  logic abs_coord = 1'b1;
  logic corner_mode = 1'b0;
  logic [31:0] move_dist = 32'h64;
  logic [31:0] corner_dist = 32'ha;
  logic [39:0] arc_radius = 40'h10;
  logic [7:0] circ_method = 8'h0;
  logic [7:0] circ_dir = 8'h0;
  // Chord of 10 gives the lowest legal radius of 4
  logic [31:0] circ_radius = 32'h4;
  logic signed [31:0] start_x = 32'sh0;
  logic signed [31:0] start_y = 32'sh0;
  logic signed [31:0] aux_x = 32'sh5;
  logic signed [31:0] aux_y = 32'sh5;
  logic signed [31:0] end_x = 32'sha;
  logic signed [31:0] end_y = 32'sh0;
  logic [3:0] axis_home_done;
  logic [3:0] axis_home_fail;
  logic cmd_ready, cmd_done, cmd_accept, cmd_reject, motion_start, homing_busy;
  logic [15:0] err_code;
  int bad_count = 0;
  int n_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  axis_group_command_checker i_dut (
    .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .group_idle_state(group_idle_state), .group_mask(group_mask),
    .axis_home_unsupported(axis_home_unsupported), .axis_home_done(axis_home_done),
    .axis_home_fail(axis_home_fail), .axis_error(axis_error),
    .axis_origin_ok(axis_origin_ok), .axis_inf_repeat(axis_inf_repeat),
    .axis_speed_limit(axis_speed_limit), .cmd_speed(cmd_speed), .abs_coord(abs_coord),
    .corner_mode(corner_mode), .move_dist(move_dist), .corner_dist(corner_dist),
    .arc_radius(arc_radius), .circ_method(circ_method), .circ_dir(circ_dir),
    .circ_radius(circ_radius), .start_x(start_x), .start_y(start_y), .aux_x(aux_x),
    .aux_y(aux_y), .end_x(end_x), .end_y(end_y), .cmd_done(cmd_done),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject), .motion_start(motion_start),
    .homing_busy(homing_busy), .err_code(err_code));

  axis_homing_model i_axes (
    .ref_clk(ref_clk), .rst(rst), .homing_busy(homing_busy), .fail_axes(fail_axes),
    .axis_home_done(axis_home_done), .axis_home_fail(axis_home_fail));

  // ****************
  // Shared tasks
  // ****************
  // One comparison, counted
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Called at an edge; returns 1 ns after the take edge
  task send(input logic [1:0] op);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask

  // Judge the answer cycle, then step to the next edge
  task ans(input logic d, a, r, m, input logic [15:0] e);
    chk("cmd_done", d, cmd_done);
    chk("cmd_accept", a, cmd_accept);
    chk("cmd_reject", r, cmd_reject);
    chk("motion_start", m, motion_start);
    chk("err_code", e, err_code);
    @(posedge ref_clk);
  endtask

  // Bounded wait for the end of a homing run
  task wait_done;
    int k;
    k = 0;
    while (cmd_done !== 1'b1 && k < 40) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
  endtask

  // ****************
  // Scenarios
  // ****************
  task t_linear;
    axis_origin_ok <= 4'h7;
    send(2'h2); ans(1, 1, 0, 1, `ERR_NONE);
    axis_origin_ok <= 4'hd;
    axis_inf_repeat <= 4'h1;
    send(2'h2); ans(1, 0, 1, 0, `ERR_LIN_NO_ORIGIN);
    // Code must outlive the pulses
    #1 chk("err_code", `ERR_LIN_NO_ORIGIN, err_code);
    chk("cmd_done", 1'b0, cmd_done);
    @(posedge ref_clk);
    abs_coord <= 1'b0;
    axis_inf_repeat <= 4'h2;
    send(2'h2); ans(1, 0, 1, 0, `ERR_LIN_INF_REPEAT);
    abs_coord <= 1'b1;
    axis_origin_ok <= 4'hf;
    axis_inf_repeat <= 4'h8;
    cmd_speed <= 32'h3e9;
    send(2'h2); ans(1, 0, 1, 0, `ERR_LIN_OVER_SPEED);
    cmd_speed <= 32'h3e8;
    corner_mode <= 1'b1;
    corner_dist <= 32'h64;
    send(2'h2); ans(1, 0, 1, 0, `ERR_LIN_CORNER_DIST);
    corner_dist <= 32'h63;
    arc_radius <= 40'h80000000;
    send(2'h2); ans(1, 0, 1, 0, `ERR_LIN_CORNER_RADIUS);
    arc_radius <= 40'h7fffffff;
    send(2'h2); ans(1, 1, 0, 1, `ERR_NONE);
    corner_mode <= 1'b0;
    $display("linear test finished");
  endtask

  task t_circle;
    // Each legal method, radius method at the exact 80 percent boundary
    for (int m = 0; m < 3; m++) begin
      circ_method <= m[7:0];
      send(2'h3); ans(1, 1, 0, 1, `ERR_NONE);
    end
    circ_method <= 8'h3;
    send(2'h3); ans(1, 0, 1, 0, `ERR_CIRC_METHOD);
    axis_origin_ok <= 4'he;
    send(2'h3); ans(1, 0, 1, 0, `ERR_CIRC_NO_ORIGIN);
    axis_origin_ok <= 4'hf;
    circ_dir <= 8'h2;
    send(2'h3); ans(1, 0, 1, 0, `ERR_CIRC_METHOD);
    circ_method <= 8'h0;
    send(2'h3); ans(1, 0, 1, 0, `ERR_CIRC_DIRECTION);
    circ_dir <= 8'h1;
    send(2'h3); ans(1, 1, 0, 1, `ERR_NONE);
    circ_method <= 8'h2;
    circ_radius <= 32'h3;
    send(2'h3); ans(1, 0, 1, 0, `ERR_CIRC_RADIUS);
    circ_radius <= 32'h4;
    end_x <= 32'sh0;
    send(2'h3); ans(1, 0, 1, 0, `ERR_CIRC_SAME_ENDS);
    circ_method <= 8'h0;
    send(2'h3); ans(1, 0, 1, 0, `ERR_CIRC_SAME_ENDS);
    circ_method <= 8'h1;
    send(2'h3); ans(1, 1, 0, 1, `ERR_NONE);
    end_x <= 32'sha;
    aux_x <= 32'sh0;
    aux_y <= 32'sh0;
    send(2'h3); ans(1, 0, 1, 0, `ERR_CIRC_AUX_POINT);
    circ_method <= 8'h2;
    send(2'h3); ans(1, 1, 0, 1, `ERR_NONE);
    circ_method <= 8'h0;
    aux_x <= 32'sha;
    send(2'h3); ans(1, 0, 1, 0, `ERR_CIRC_AUX_POINT);
    aux_x <= 32'sh5;
    aux_y <= 32'sh5;
    $display("circular test finished");
  endtask

  task t_setpos;
    axis_error <= 4'h2;
    send(2'h1); ans(1, 0, 1, 0, `ERR_SETPOS_AXIS_ERROR);
    axis_error <= 4'h8;
    send(2'h1); ans(1, 1, 0, 0, `ERR_NONE);
    $display("set position test finished");
  endtask

  task t_home;
    group_idle_state <= 1'b0;
    axis_home_unsupported <= 4'h1;
    send(2'h0); ans(1, 0, 1, 0, `ERR_HOME_BUSY);
    group_idle_state <= 1'b1;
    send(2'h0); ans(1, 0, 1, 0, `ERR_HOME_UNSUPPORTED);
    axis_home_unsupported <= 4'h8;
    send(2'h0); ans(0, 1, 0, 1, `ERR_NONE);
    // A command offered mid-run must be ignored
    cmd_valid <= 1'b1;
    cmd_op <= 2'h2;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1 chk("cmd_ready", 1'b0, cmd_ready);
    chk("homing_busy", 1'b1, homing_busy);
    chk("cmd_done", 1'b0, cmd_done);
    wait_done;
    ans(1, 0, 0, 0, `ERR_NONE);
    fail_axes <= 4'h2;
    send(2'h0); ans(0, 1, 0, 1, `ERR_NONE);
    #1 wait_done;
    ans(1, 0, 1, 0, `ERR_HOME_INCOMPLETE);
    fail_axes <= 4'h0;
    $display("homing test finished");
  endtask

  // ****************
  // Verdict, sequence and watchdog
  // ****************
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1 chk("err_code", `ERR_NONE, err_code);
    chk("cmd_ready", 1'b1, cmd_ready);
    @(posedge ref_clk);
    t_linear;
    t_circle;
    t_setpos;
    t_home;
    print_verdict;
  end

  // Whole run is under a hundred cycles; 2000 cycles means a hang
  initial begin
    #10000;
    bad_count++;
    print_verdict;
  end
endmodule

//--- test/axis_homing_model.sv
// Behavioural model of the group axes answering a homing run
`timescale 1ns/1ps
module axis_homing_model #(
  parameter int N_AXES = 4,
  parameter int HOME_DLY = 6
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic homing_busy,
  input wire logic [N_AXES-1:0] fail_axes,
  output logic [N_AXES-1:0] axis_home_done,
  output logic [N_AXES-1:0] axis_home_fail
);
  // Cycles spent homing so far
  int cnt_reg;

  // ****************
  // Homing progress
  // ****************
  // Counter parks at the end, clears once the run is over
  always_ff @(posedge ref_clk) begin
    if (rst || !homing_busy) begin
      cnt_reg <= 0;
    end else if (cnt_reg < HOME_DLY) begin
      cnt_reg <= cnt_reg + 1;
    end
  end
  // Failed axes never report done, so the checker must notice the fail itself
  assign axis_home_done = (cnt_reg == HOME_DLY) ? ~fail_axes : '0;
  assign axis_home_fail = (cnt_reg == HOME_DLY) ? fail_axes : '0;
endmodule
